// File: port_ctl_pkg.sv
// Constants, register map and types for the port direction and wake block
//
// Contract
// - Nibble wake bit enables its four-pin group
// - Seven-pin Port B upper bit covers pins six-four
// - Port E pin one never wakes
// - Largest variant upper Port E bit covers five-four
// - Port A edge bit: 0 rising, 1 falling
// - Pin n maps to direction bit n
// - Direction 1: input, read returns pin level
// - Direction 0: CMOS output drives data latch
// - Output pin read returns latch, not pin
// - Direction changes act immediately, no reset needed
// - Unimplemented bits ignore writes, read zero
// - Supply code 0x main, 10 io, 11 regulator
// - Supply select on Port A and D[7:4]
// - Largest Port E direction bits five-zero
// - Each Port A pin has wake enable
// - Qualifying edge on enabled pin raises wake
// - After reset latches and directions read one
package port_ctl_pkg;

  // ==========================================================
  // Register map (word indices on the plain port)
  localparam logic [4:0] a_data_idx    = 5'h00;
  localparam logic [4:0] b_data_idx    = 5'h01;
  localparam logic [4:0] c_data_idx    = 5'h02;
  localparam logic [4:0] d_data_idx    = 5'h03;
  localparam logic [4:0] e_data_idx    = 5'h04;
  localparam logic [4:0] a_dir_idx     = 5'h05;
  localparam logic [4:0] b_dir_idx     = 5'h06;
  localparam logic [4:0] c_dir_idx     = 5'h07;
  localparam logic [4:0] d_dir_idx     = 5'h08;
  localparam logic [4:0] e_dir_idx     = 5'h09;
  localparam logic [4:0] a_wake_idx    = 5'h0a;
  localparam logic [4:0] nib_wake_idx  = 5'h0b;
  localparam logic [4:0] a_edge_idx    = 5'h0c;
  localparam logic [4:0] a_sup_lo_idx  = 5'h0d;
  localparam logic [4:0] a_sup_hi_idx  = 5'h0e;
  localparam logic [4:0] d_sup_idx     = 5'h0f;
  localparam logic [4:0] irq_stat_idx  = 5'h10;
  localparam logic [4:0] irq_mask_idx  = 5'h11;

  // ==========================================================
  // Implemented bit masks for the largest variant
  localparam logic [7:0] full_mask     = 8'hff;
  localparam logic [7:0] porte_mask    = 8'h3f;
  localparam logic [7:0] zero_byte     = 8'h00;
  localparam logic [7:0] ones_byte     = 8'hff;
  localparam logic [7:0] porte_wake_ok = 8'h3d;

  // Nibble wake enable field positions
  localparam int nib_b_lo = 0;
  localparam int nib_b_hi = 1;
  localparam int nib_c_lo = 2;
  localparam int nib_c_hi = 3;
  localparam int nib_d_lo = 4;
  localparam int nib_d_hi = 5;
  localparam int nib_e_lo = 6;
  localparam int nib_e_hi = 7;

  // Interrupt status bit positions
  localparam int irq_wake_bit = 0;
  localparam int irq_dir_bit  = 1;
  localparam logic [7:0] irq_mask_bits = 8'h03;

  // ==========================================================
  // Supply source codes
  typedef enum logic [1:0] {
    sup_main0 = 2'b00,
    sup_main1 = 2'b01,
    sup_io    = 2'b10,
    sup_reg33 = 2'b11
  } supply_code_t;

  // Decoded one-hot supply choice for a pin
  typedef struct packed {
    logic main_rail;
    logic io_rail;
    logic reg_rail;
  } supply_sel_t;

  // Five ports of eight bits
  typedef struct packed {
    logic [7:0] e;
    logic [7:0] d;
    logic [7:0] c;
    logic [7:0] b;
    logic [7:0] a;
  } port_bus_t;

  // Register port request
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage : port_ctl_pkg

// File: port_direction_wake_select.sv
// Port direction, read-back and wake logic for Ports A to E, supply-select logic for Port A and Port D
`timescale 1ns/100ps
`default_nettype none

module port_direction_wake_select (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  // Register port
  input  wire port_ctl_pkg::reg_req_t        req,
  output logic [7:0]                         rdata,
  // Pads
  input  wire port_ctl_pkg::port_bus_t       pin_in,
  output port_ctl_pkg::port_bus_t            pin_out,
  output port_ctl_pkg::port_bus_t            pin_oe,
  // Supply selection, Port A pins 0-7 then Port D pins 4-7
  output port_ctl_pkg::supply_sel_t [11:0]   pin_supply,
  // Power-mode controller and interrupt
  output logic                               wake_req,
  output logic                               irq
);

  // ==========================================================
  // Registers
  port_ctl_pkg::port_bus_t data_latch;
  port_ctl_pkg::port_bus_t dir;
  logic [7:0]  a_wake_en;
  logic [7:0]  nib_wake;
  logic [7:0]  a_edge;
  logic [7:0]  a_sup_lo;
  logic [7:0]  a_sup_hi;
  logic [7:0]  d_sup;
  logic [7:0]  irq_stat;
  logic [7:0]  irq_mask;

  // ==========================================================
  // Pin input synchronisers: three stages, change counted when 2 and 3 agree
  logic [39:0] sync1;
  logic [39:0] sync2;
  logic [39:0] sync3;
  logic [39:0] pin_level;
  // Warm-up chain: one stage per flop between the pad and level_prev
  logic [3:0]  warm;
  logic        primed;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1     <= '0;
      sync2     <= '0;
      sync3     <= '0;
      pin_level <= '0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3 || !warm[3]) begin
        pin_level <= sync3;
      end
    end
  end

  // Edges stay blanked until level_prev holds a real pad sample, so a pad
  // that idles high is not taken for a rising edge after reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      warm   <= '0;
      primed <= 1'b0;
    end else begin
      warm   <= {warm[2:0], 1'b1};
      primed <= warm[3];
    end
  end

  // ==========================================================
  // Address decode
  wire w_a_data  = req.wr && req.addr == port_ctl_pkg::a_data_idx;
  wire w_b_data  = req.wr && req.addr == port_ctl_pkg::b_data_idx;
  wire w_c_data  = req.wr && req.addr == port_ctl_pkg::c_data_idx;
  wire w_d_data  = req.wr && req.addr == port_ctl_pkg::d_data_idx;
  wire w_e_data  = req.wr && req.addr == port_ctl_pkg::e_data_idx;
  wire w_a_dir   = req.wr && req.addr == port_ctl_pkg::a_dir_idx;
  wire w_b_dir   = req.wr && req.addr == port_ctl_pkg::b_dir_idx;
  wire w_c_dir   = req.wr && req.addr == port_ctl_pkg::c_dir_idx;
  wire w_d_dir   = req.wr && req.addr == port_ctl_pkg::d_dir_idx;
  wire w_e_dir   = req.wr && req.addr == port_ctl_pkg::e_dir_idx;
  wire w_a_wake  = req.wr && req.addr == port_ctl_pkg::a_wake_idx;
  wire w_nib     = req.wr && req.addr == port_ctl_pkg::nib_wake_idx;
  wire w_a_edge  = req.wr && req.addr == port_ctl_pkg::a_edge_idx;
  wire w_a_sl    = req.wr && req.addr == port_ctl_pkg::a_sup_lo_idx;
  wire w_a_sh    = req.wr && req.addr == port_ctl_pkg::a_sup_hi_idx;
  wire w_d_sup   = req.wr && req.addr == port_ctl_pkg::d_sup_idx;
  wire w_stat    = req.wr && req.addr == port_ctl_pkg::irq_stat_idx;
  wire w_mask    = req.wr && req.addr == port_ctl_pkg::irq_mask_idx;

  // Port E bits 7-6 are not implemented: masked on write
  wire [7:0] e_wdata = req.wdata & port_ctl_pkg::porte_mask;

  // ==========================================================
  // Data latches and direction registers; direction acts next cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Port E bits 7-6 do not exist, so they must not come up driven
      data_latch <= {port_ctl_pkg::porte_mask,
                     {4{port_ctl_pkg::ones_byte}}};
      dir        <= {port_ctl_pkg::porte_mask,
                     {4{port_ctl_pkg::ones_byte}}};
    end else begin
      if (w_a_data) data_latch.a <= req.wdata;
      if (w_b_data) data_latch.b <= req.wdata;
      if (w_c_data) data_latch.c <= req.wdata;
      if (w_d_data) data_latch.d <= req.wdata;
      if (w_e_data) data_latch.e <= e_wdata;
      if (w_a_dir)  dir.a        <= req.wdata;
      if (w_b_dir)  dir.b        <= req.wdata;
      if (w_c_dir)  dir.c        <= req.wdata;
      if (w_d_dir)  dir.d        <= req.wdata;
      if (w_e_dir)  dir.e        <= e_wdata;
    end
  end

  // ==========================================================
  // Wake and supply configuration
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      a_wake_en <= port_ctl_pkg::zero_byte;
      nib_wake  <= port_ctl_pkg::zero_byte;
      a_edge    <= port_ctl_pkg::zero_byte;
      a_sup_lo  <= port_ctl_pkg::zero_byte;
      a_sup_hi  <= port_ctl_pkg::zero_byte;
      d_sup     <= port_ctl_pkg::zero_byte;
      irq_mask  <= port_ctl_pkg::zero_byte;
    end else begin
      if (w_a_wake) a_wake_en <= req.wdata;
      if (w_nib)    nib_wake  <= req.wdata;
      if (w_a_edge) a_edge    <= req.wdata;
      if (w_a_sl)   a_sup_lo  <= req.wdata;
      if (w_a_sh)   a_sup_hi  <= req.wdata;
      if (w_d_sup)  d_sup     <= req.wdata;
      if (w_mask)   irq_mask  <= req.wdata & port_ctl_pkg::irq_mask_bits;
    end
  end

  // ==========================================================
  // Pad drive: output enable is the inverse of the direction bit, except Port E bits 7-6 which are held off
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= data_latch & ~dir;
      pin_oe  <= ~dir & {port_ctl_pkg::porte_mask,
                         {4{port_ctl_pkg::full_mask}}};
    end
  end

  // ==========================================================
  // Read-back: input pins show level, output pins show latch
  wire [39:0] port_view = (pin_level & dir) | (data_latch & ~dir);

  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = port_ctl_pkg::zero_byte;
    if (req.rd) begin
      unique case (req.addr)
        port_ctl_pkg::a_data_idx:   next_rdata = port_view[7:0];
        port_ctl_pkg::b_data_idx:   next_rdata = port_view[15:8];
        port_ctl_pkg::c_data_idx:   next_rdata = port_view[23:16];
        port_ctl_pkg::d_data_idx:   next_rdata = port_view[31:24];
        port_ctl_pkg::e_data_idx:   next_rdata = port_view[39:32]
                                      & port_ctl_pkg::porte_mask;
        port_ctl_pkg::a_dir_idx:    next_rdata = dir.a;
        port_ctl_pkg::b_dir_idx:    next_rdata = dir.b;
        port_ctl_pkg::c_dir_idx:    next_rdata = dir.c;
        port_ctl_pkg::d_dir_idx:    next_rdata = dir.d;
        port_ctl_pkg::e_dir_idx:    next_rdata = dir.e;
        port_ctl_pkg::a_wake_idx:   next_rdata = a_wake_en;
        port_ctl_pkg::nib_wake_idx: next_rdata = nib_wake;
        port_ctl_pkg::a_edge_idx:   next_rdata = a_edge;
        port_ctl_pkg::a_sup_lo_idx: next_rdata = a_sup_lo;
        port_ctl_pkg::a_sup_hi_idx: next_rdata = a_sup_hi;
        port_ctl_pkg::d_sup_idx:    next_rdata = d_sup;
        port_ctl_pkg::irq_stat_idx: next_rdata = irq_stat;
        port_ctl_pkg::irq_mask_idx: next_rdata = irq_mask;
        default:                    next_rdata = port_ctl_pkg::zero_byte;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= port_ctl_pkg::zero_byte;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Wake enable per pin
  wire [3:0] nib_b_lo = {4{nib_wake[port_ctl_pkg::nib_b_lo]}};
  wire [3:0] nib_b_hi = {4{nib_wake[port_ctl_pkg::nib_b_hi]}};
  wire [3:0] nib_c_lo = {4{nib_wake[port_ctl_pkg::nib_c_lo]}};
  wire [3:0] nib_c_hi = {4{nib_wake[port_ctl_pkg::nib_c_hi]}};
  wire [3:0] nib_d_lo = {4{nib_wake[port_ctl_pkg::nib_d_lo]}};
  wire [3:0] nib_d_hi = {4{nib_wake[port_ctl_pkg::nib_d_hi]}};
  wire [3:0] nib_e_lo = {4{nib_wake[port_ctl_pkg::nib_e_lo]}};
  wire [3:0] nib_e_hi = {4{nib_wake[port_ctl_pkg::nib_e_hi]}};
  wire [39:0] wake_en = {
    {nib_e_hi, nib_e_lo} & port_ctl_pkg::porte_wake_ok,
    nib_d_hi, nib_d_lo,
    nib_c_hi, nib_c_lo,
    nib_b_hi, nib_b_lo,
    a_wake_en
  };

  // ==========================================================
  // Edge detection: Port A follows its edge bit, others wake on fall
  logic [39:0] level_prev;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      level_prev <= '0;
    end else begin
      level_prev <= pin_level;
    end
  end

  wire [39:0] fall_pref = {{4{port_ctl_pkg::ones_byte}}, a_edge};
  wire [39:0] rose = pin_level & ~level_prev;
  wire [39:0] fell = ~pin_level & level_prev;
  wire [39:0] hit  = ((rose & ~fall_pref) | (fell & fall_pref))
                     & wake_en;
  wire        any_hit = primed && (|hit);

  // Wake request is a registered level pulse for the mode controller
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= any_hit;
    end
  end

  // ==========================================================
  // Interrupt status: set wins over a write-one clear
  wire dir_written = w_a_dir | w_b_dir | w_c_dir | w_d_dir | w_e_dir;
  wire [7:0] set_bits = {6'h00, dir_written, any_hit};
  wire [7:0] clr_bits = w_stat ? req.wdata : port_ctl_pkg::zero_byte;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat <= port_ctl_pkg::zero_byte;
      irq      <= 1'b0;
    end else begin
      irq_stat <= ((irq_stat & ~clr_bits) | set_bits)
                  & port_ctl_pkg::irq_mask_bits;
      irq      <= |(irq_stat & irq_mask);
    end
  end

  // ==========================================================
  // Supply decode: 0x main rail, 10 io rail, 11 regulator
  wire [23:0] sup_codes = {d_sup, a_sup_hi, a_sup_lo};
  port_ctl_pkg::supply_sel_t [11:0] next_supply;

  genvar g;
  generate
    for (g = 0; g < 12; g++) begin : g_sup
      port_ctl_pkg::supply_code_t code;
      assign code = port_ctl_pkg::supply_code_t'(sup_codes[2*g +: 2]);
      assign next_supply[g].main_rail =
        code == port_ctl_pkg::sup_main0 || code == port_ctl_pkg::sup_main1;
      assign next_supply[g].io_rail  = code == port_ctl_pkg::sup_io;
      assign next_supply[g].reg_rail = code == port_ctl_pkg::sup_reg33;
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_supply <= {12{3'b100}};
    end else begin
      pin_supply <= next_supply;
    end
  end

endmodule : port_direction_wake_select

`default_nettype wire

// File: port_dir_checker_assertions.sv
// Checker for the port direction and wake block
`timescale 1ns/100ps
`default_nettype none

module port_dir_checker (
  // Clock and reset
  input wire logic                             sys_clk,
  input wire logic                             rst_b,
  // Register port
  input wire port_ctl_pkg::reg_req_t           req,
  input wire logic [7:0]                       rdata,
  // Pads
  input wire port_ctl_pkg::port_bus_t          pin_in,
  input wire port_ctl_pkg::port_bus_t          pin_out,
  input wire port_ctl_pkg::port_bus_t          pin_oe,
  input wire port_ctl_pkg::supply_sel_t [11:0] pin_supply,
  // Power and interrupt
  input wire logic                             wake_req,
  input wire logic                             irq
);
  // ==========================================================
  // Helpers
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [3:0] quiet;
  wire logic       dir_wr = req.wr && req.addr == port_ctl_pkg::a_dir_idx;
  wire logic       sup_wr = req.wr && req.addr == port_ctl_pkg::a_sup_lo_idx;
  wire logic       dsp_wr = req.wr && req.addr == port_ctl_pkg::d_sup_idx;
  wire logic       hi_rd  = req.rd && req.addr > port_ctl_pkg::irq_mask_idx;
  wire logic       e_rd   = req.rd && req.addr == port_ctl_pkg::e_dir_idx;
  wire logic [1:0] code   = req.wdata[1:0];

  // Cycles since a pad last moved; a wake with no pad activity is bogus
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) quiet <= 4'h0;
    else if (pin_in != $past(pin_in)) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;

  // ==========================================================
  // Properties
  property p_dir_oe;
    dir_wr ##1 !dir_wr |-> ##1 pin_oe.a == ~$past(req.wdata, 2);
  endproperty
  property p_e_oe;
    pin_oe.e[7:6] == 2'b00;
  endproperty
  property p_out_oe;
    (pin_out & ~pin_oe) == 40'h0;
  endproperty
  property p_wake_src;
    wake_req |-> quiet < 4'ha;
  endproperty
  property p_hi_rd;
    hi_rd |=> rdata == 8'h00;
  endproperty
  property p_e_rd;
    e_rd |=> rdata[7:6] == 2'b00;
  endproperty
  property p_sup;
    sup_wr ##1 !sup_wr |-> ##1 pin_supply[0] == {!$past(code[1], 2),
      $past(code, 2) == 2'b10, $past(code, 2) == 2'b11};
  endproperty
  property p_dsup;
    $changed(pin_supply[11:8]) |-> $past(dsp_wr, 2);
  endproperty

  a_dir_oe: assert property (p_dir_oe) else $error("oe off dir");
  a_e_oe: assert property (p_e_oe) else $error("port e oe high");
  a_out_oe: assert property (p_out_oe) else $error("undriven out");
  a_wake_src: assert property (p_wake_src) else $error("stray wake");
  a_hi_rd: assert property (p_hi_rd) else $error("unmapped read");
  a_e_rd: assert property (p_e_rd) else $error("port e high bits");
  a_sup: assert property (p_sup) else $error("supply decode");
  a_dsup: assert property (p_dsup) else $error("d supply moved");

  c_wake: cover property (wake_req);
  c_irq: cover property ($rose(irq));
  c_dir: cover property (dir_wr ##1 !dir_wr);
endmodule : port_dir_checker

bind port_direction_wake_select port_dir_checker u_chk (.sys_clk, .rst_b,
  .req, .rdata, .pin_in, .pin_out, .pin_oe, .pin_supply, .wake_req, .irq);

`default_nettype wire

// File: pad_switches.sv
// Model of switches and loads on the port pads
`timescale 1ns/100ps
`default_nettype none

module pad_switches (
  // Bench controls
  input  wire port_ctl_pkg::port_bus_t sw,
  input  wire port_ctl_pkg::port_bus_t clamp,
  // Device pads
  input  wire port_ctl_pkg::port_bus_t pin_out,
  input  wire port_ctl_pkg::port_bus_t pin_oe,
  output var  port_ctl_pkg::port_bus_t pin_in
);
  // ==========================================================
  // Pad level
  // A clamp shorts a pad low even when driven, so a read can tell
  // the output latch from the real pad level
  assign pin_in = port_ctl_pkg::port_bus_t'(((pin_out & pin_oe) |
                  (sw & ~pin_oe)) & ~clamp);
endmodule : pad_switches

`default_nettype wire

// File: port_direction_wake_select_tb_top.sv
// Self-checking bench for the port direction and wake block
`timescale 1ns/100ps
`default_nettype none

module port_direction_wake_select_tb_top;
  // ==========================================================
  // Signals
  logic                             sys_clk = 1'b0;
  logic                             rst_b   = 1'b0;
  port_ctl_pkg::reg_req_t           req     = '0;
  port_ctl_pkg::port_bus_t          sw      = '1;
  port_ctl_pkg::port_bus_t          clamp   = '0;
  port_ctl_pkg::port_bus_t          pin_in, pin_out, pin_oe;
  port_ctl_pkg::supply_sel_t [11:0] pin_supply;
  logic [7:0]                       rdata, m;
  logic                             wake_req, irq;
  int                               n_fail = 0;
  int                               n_checks = 0;
  int                               k, c, j;

  always #2.5 sys_clk = ~sys_clk;

  port_direction_wake_select dut (.sys_clk, .rst_b, .req, .rdata, .pin_in,
    .pin_out, .pin_oe, .pin_supply, .wake_req, .irq);
  pad_switches pads (.sw, .clamp, .pin_out, .pin_oe, .pin_in);

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask : rd

  // Move one pad and count wake pulses over the sync delay
  task automatic wk(input int p, input logic v, input int e);
    int n = 0;
    @(posedge sys_clk);
    sw[p] <= v;
    repeat (10) begin
      @(posedge sys_clk);
      #1 if (wake_req === 1'b1) n++;
    end
    chk("wake pulses", e[7:0], n[7:0]);
  endtask : wk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // ==========================================================
  // Tests
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge sys_clk);
    for (k = 0; k < 18; k++) rd(k[4:0], k > 9 ? 8'h00 :
      (k % 5 == 4) ? 8'h3f : 8'hff);
    chk("oe", 8'h00, pin_oe.a);
    $display("test reset values done");
    wr(5'h12, 8'hff);
    rd(5'h12, 8'h00);
    rd(5'h1f, 8'h00);
    wr(port_ctl_pkg::e_dir_idx, 8'hc0);
    rd(port_ctl_pkg::e_dir_idx, 8'h00);
    wr(port_ctl_pkg::irq_mask_idx, 8'hff);
    rd(port_ctl_pkg::irq_mask_idx, 8'h03);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq", 8'h01, {7'h0, irq});
    wr(port_ctl_pkg::irq_mask_idx, 8'h01);
    $display("test reserved bits done");
    sw <= {5{8'h5a}};
    clamp <= {5{8'hcc}};
    for (k = 0; k < 5; k++) begin
      m = (k == 4) ? 8'h3f : 8'hff;
      wr(k[4:0], 8'h0f);
      wr(k[4:0] + 5'h05, 8'h33);
      repeat (6) @(posedge sys_clk);
      #1 chk("oe", 8'hcc & m, pin_oe[8*k+:8]);
      chk("out", 8'h0c & m, pin_out[8*k+:8]);
      rd(k[4:0], 8'h1e & m);
      wr(k[4:0] + 5'h05, 8'hff);
      repeat (2) @(posedge sys_clk);
      #1 chk("oe", 8'h00, pin_oe[8*k+:8]);
    end
    chk("irq masked", 8'h00, {7'h0, irq});
    $display("test direction done");
    for (c = 0; c < 4; c++)
      for (k = 0; k < 3; k++) begin
        wr(port_ctl_pkg::a_sup_lo_idx + k[4:0], {4{c[1:0]}});
        rd(port_ctl_pkg::a_sup_lo_idx + k[4:0], {4{c[1:0]}});
        for (j = 0; j < 4; j++) chk("supply", {5'h0, !c[1], c == 2, c == 3},
          pin_supply[4*k+j]);
      end
    $display("test supply done");
    sw <= '1;
    clamp <= '0;
    wr(port_ctl_pkg::irq_stat_idx, 8'h03);
    wk(8, 1'b0, 0);
    wk(8, 1'b1, 0);
    for (k = 0; k < 8; k++) begin
      wr(port_ctl_pkg::nib_wake_idx, 8'h01 << k);
      wk(8 + 8 * (k / 2) + 4 * (k % 2), 1'b0, 1);
      wk(8 + 8 * (k / 2) + 4 * (k % 2), 1'b1, 0);
    end
    wr(port_ctl_pkg::nib_wake_idx, 8'h40);
    wk(33, 1'b0, 0);
    wk(34, 1'b0, 1);
    wr(port_ctl_pkg::a_wake_idx, 8'h08);
    wk(3, 1'b0, 0);
    wk(3, 1'b1, 1);
    wr(port_ctl_pkg::a_edge_idx, 8'h08);
    wk(3, 1'b0, 1);
    wk(4, 1'b0, 0);
    chk("irq", 8'h01, {7'h0, irq});
    rd(port_ctl_pkg::irq_stat_idx, 8'h01);
    wr(port_ctl_pkg::irq_stat_idx, 8'h01);
    rd(port_ctl_pkg::irq_stat_idx, 8'h00);
    #1 chk("irq", 8'h00, {7'h0, irq});
    $display("test wake done");
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end
endmodule : port_direction_wake_select_tb_top

`default_nettype wire
